// ==== hdl/ssx_pkg.sv ====
// Shared constants and types for the sweep sync and external control block
`default_nettype none
package ssx_pkg;

   // ***********************************************
   // Sweep progress and marker limits
   // ***********************************************
   localparam int PROG_W = 15; // Sweep time split into 32768 steps
   localparam logic [PROG_W-1:0] PROG_FIRST = 15'h0000;
   localparam logic [PROG_W-1:0] PROG_LAST = 15'h7FFF;
   localparam logic [PROG_W-1:0] MK_MIN_IDX = 15'h0010; // About 0.05 percent
   localparam logic [PROG_W-1:0] MK_MAX_IDX = 15'h7FF0; // About 99.95 percent

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_PERIOD_PS = 20000;
   localparam int STEP_MIN_PS = 8330; // Finest marker step, 8.33 ns
   localparam int STEP_MIN_RAW = (STEP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STEP_MIN_CYC = (STEP_MIN_RAW < 1) ? 1 : STEP_MIN_RAW;

   // ***********************************************
   // Modes and selections
   // ***********************************************
   typedef enum logic [1:0] {
      SSX_SYNC_REF_PHASE = 2'b00,
      SSX_SYNC_SWEEP_LEVEL = 2'b01,
      SSX_SYNC_LEVEL_MARKER = 2'b10,
      SSX_SYNC_X_DRIVE = 2'b11
   } ssx_sync_sel_e;

   typedef enum logic [1:0] {
      SSX_RUN_CONTINUOUS = 2'b00,
      SSX_RUN_SINGLE = 2'b01,
      SSX_RUN_GATED_SINGLE = 2'b10
   } ssx_run_mode_e;

   typedef enum logic [1:0] {
      SSX_SHAPE_LINEAR_SINGLE_DIRECTION = 2'b00,
      SSX_SHAPE_LINEAR_SHUTTLE = 2'b01,
      SSX_SHAPE_LOGARITHMIC_SINGLE_DIRECTION = 2'b10,
      SSX_SHAPE_LOGARITHMIC_SHUTTLE = 2'b11
   } ssx_shape_e;

   typedef enum logic [2:0] {
      SSX_WAVE_SINE = 3'h0,
      SSX_WAVE_SQUARE = 3'h1,
      SSX_WAVE_PULSE = 3'h2,
      SSX_WAVE_RAMP = 3'h3,
      SSX_WAVE_NOISE = 3'h4,
      SSX_WAVE_DC = 3'h5,
      SSX_WAVE_ARB = 3'h6
   } ssx_wave_e;

   typedef enum logic [2:0] {
      SSX_TYPE_FREQ = 3'h0,
      SSX_TYPE_PHASE = 3'h1,
      SSX_TYPE_AMPLITUDE = 3'h2,
      SSX_TYPE_OFFSET = 3'h3,
      SSX_TYPE_DUTY = 3'h4
   } ssx_type_e;

   localparam int TYPE_COUNT = 5;

   typedef enum logic [2:0] {
      SSX_ST_START_VALUE = 3'b000,
      SSX_ST_RUN_FWD = 3'b001,
      SSX_ST_RUN_RETURN = 3'b010,
      SSX_ST_HOLD = 3'b011,
      SSX_ST_COMPLETE = 3'b100
   } ssx_state_e;

   // External TTL control pins, as levels
   typedef struct packed {
      logic start;
      logic stop;
      logic hold;
   } ssx_ext_s;

   localparam int EXT_W = 3;

endpackage
`default_nettype wire

// ==== hdl/ssx_edge_detect.sv ====
// Edge detector for the external control pins, gated by an enable
`default_nettype none
module ssx_edge_detect #(
   parameter int W = 3
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic [W-1:0] level,
   output logic [W-1:0] fall,
   output logic [W-1:0] rise
);

   logic [W-1:0] prev_q;

   // ***********************************************
   // Per-pin edge logic
   // ***********************************************
   // Previous level resets high so an idle-high pin gives no false edge
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prev_q <= '1;
      end else begin
         prev_q <= level;
      end
   end

   for (genvar i = 0; i < W; i++) begin : g_pin
      // Edges are dropped while control is off, not queued
      assign fall[i] = enable & prev_q[i] & ~level[i];
      assign rise[i] = enable & ~prev_q[i] & level[i];
   end

endmodule
`default_nettype wire

// ==== hdl/ssx_sweep_sync.sv ====
// Sweep sequencer with sync, marker and X-drive output and external control
`default_nettype none
// Overview of operation
// R1: Sync output source is one of four selectable forms.
// R2: Reference-phase form rises at each waveform cycle's reference phase.
// R3: Sweep level form is high before a sweep, falls at sweep start.
// R4: Marker form stays low from sweep start until the marker value is reached.
// R5: Marker form does not change on the shuttle return leg.
// R6: Marker low-time clamped to about 0.05 to 99.95 percent of sweep.
// R7: Marker step is sweep time over 32768, never under 8.33 ns.
// R8: X-drive code ramps 0 to full scale linearly with elapsed time.
// R9: X-drive stays linear in time even for logarithmic sweeps.
// R10: Stop below start reverses the X-drive slope.
// R11: Copy commands move center to marker or marker to center.
// R12: External control acts only while its single enable is on.
// R13: External start falling edge restarts the sweep from its start.
// R14: In triggered modes external start is ORed with the trigger.
// R15: External stop falling edge halts sweep in start-value state.
// R16: After a stop in triggered modes, next trigger restarts sweep.
// R17: Hold falling edge freezes sweep, rising edge resumes it.
// R18: Trigger during hold in triggered modes restarts from start.
// R19: Frequency sweep refused for noise, pulse or DC.
// R20: Phase sweep refused for noise or DC.
// R21: Swept parameter uses sweep settings instead of its static value.
// R22: Halted level and half-cycle stop apply only in gated mode.
// R23: Single mode: one-way returns to start, shuttle waits complete.
// R24: Start, stop and hold edges ignored while external control is off.
module ssx_sweep_sync #(
   parameter int VAL_W = 16,
   parameter int CNT_W = 24,
   parameter int XD_W = 12
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire ssx_pkg::ssx_sync_sel_e sync_output_select,
   input wire ssx_pkg::ssx_run_mode_e sweep_run_mode,
   input wire ssx_pkg::ssx_shape_e sweep_shape_function,
   input wire ssx_pkg::ssx_type_e sweep_type,
   input wire ssx_pkg::ssx_wave_e waveform,
   input wire logic sweep_enable,
   input wire logic external_control_enable,
   input wire ssx_pkg::ssx_ext_s ext_pins,
   input wire logic trig_in,
   input wire logic wave_phase_msb,
   input wire logic [CNT_W-1:0] step_cycles,
   input wire logic [VAL_W-1:0] start_value,
   input wire logic [VAL_W-1:0] stop_value,
   input wire logic marker_wr,
   input wire logic [VAL_W-1:0] marker_wdata,
   input wire logic center_wr,
   input wire logic [VAL_W-1:0] center_wdata,
   input wire logic copy_center_to_marker,
   input wire logic copy_marker_to_center,
   input wire logic halted_output_level,
   input wire logic halt_granularity,
   output logic sync_out,
   output logic [XD_W-1:0] xdrive_code,
   output logic [VAL_W-1:0] swept_value,
   output logic [VAL_W-1:0] marker_value,
   output logic [VAL_W-1:0] center_value,
   output ssx_pkg::ssx_state_e sweep_state,
   output logic sweep_conflict,
   output logic [ssx_pkg::TYPE_COUNT-1:0] param_override,
   output logic halted_level_active,
   output logic halt_half_cycle
);

   // ***********************************************
   // Elaboration checks
   // ***********************************************
   if (XD_W < 2 || XD_W > ssx_pkg::PROG_W || VAL_W < 2 || CNT_W < 2) begin : g_bad
      $error("ssx_sweep_sync: unsupported width parameter");
   end

   localparam logic [CNT_W-1:0] STEP_MIN = CNT_W'(ssx_pkg::STEP_MIN_CYC);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [ssx_pkg::PROG_W-1:0] PROG_ONE = ssx_pkg::PROG_W'(1);

   // ***********************************************
   // Declarations
   // ***********************************************
   ssx_pkg::ssx_ext_s ext_fall;
   ssx_pkg::ssx_ext_s ext_rise;
   ssx_pkg::ssx_state_e state_q, state_d;
   logic [ssx_pkg::PROG_W-1:0] prog_q, prog_d;
   logic [CNT_W-1:0] step_cnt_q;
   logic [CNT_W-1:0] step_eff;
   logic step_tick;
   logic stopped_q;
   logic ret_leg_q;
   logic conflict;
   logic ok;
   logic triggered_mode;
   logic shuttle;
   logic descend;
   logic start_ev, stop_ev, hold_ev, resume_ev, cont_auto;
   logic running;
   logic signed [VAL_W:0] diff_s;
   logic signed [VAL_W+ssx_pkg::PROG_W+1:0] prod_s;
   logic signed [VAL_W+1:0] val_s;
   logic [VAL_W-1:0] lin_value;
   logic reached;
   logic marker_low;
   logic sync_d;
   logic [XD_W-1:0] xd_base;

   // ***********************************************
   // External pin edges
   // ***********************************************
   // Enable gates edges at the source, so a disabled pin never acts [R12] [R24]
   ssx_edge_detect #(
      .W(ssx_pkg::EXT_W)
   ) u_edges (
      .mclk(mclk),
      .rst_n(rst_n),
      .enable(external_control_enable),
      .level(ext_pins),
      .fall(ext_fall),
      .rise(ext_rise)
   );

   // ***********************************************
   // Mode decode and waveform restrictions
   // ***********************************************
   // Refused combinations keep the sweep parked and block triggers
   always_comb begin
      conflict = 1'b0;
      if (sweep_type == ssx_pkg::SSX_TYPE_FREQ) begin
         conflict = (waveform == ssx_pkg::SSX_WAVE_NOISE) || // [R19]
            (waveform == ssx_pkg::SSX_WAVE_PULSE) || (waveform == ssx_pkg::SSX_WAVE_DC);
      end else if (sweep_type == ssx_pkg::SSX_TYPE_PHASE) begin
         conflict = (waveform == ssx_pkg::SSX_WAVE_NOISE) || // [R20]
            (waveform == ssx_pkg::SSX_WAVE_DC);
      end
   end

   assign ok = sweep_enable & ~conflict;
   assign triggered_mode = (sweep_run_mode == ssx_pkg::SSX_RUN_SINGLE) ||
      (sweep_run_mode == ssx_pkg::SSX_RUN_GATED_SINGLE);
   assign shuttle = sweep_shape_function[0];
   assign descend = stop_value < start_value;
   assign running = (state_q == ssx_pkg::SSX_ST_RUN_FWD) ||
      (state_q == ssx_pkg::SSX_ST_RUN_RETURN);

   // Start from the pin, or from the trigger in triggered modes [R13] [R14]
   assign start_ev = ok & (ext_fall.start | (triggered_mode & trig_in));
   assign stop_ev = ext_fall.stop & (running | (state_q == ssx_pkg::SSX_ST_HOLD)); // [R15]
   assign hold_ev = ext_fall.hold & running; // [R17]
   assign resume_ev = ext_rise.hold & (state_q == ssx_pkg::SSX_ST_HOLD); // [R17]
   // Continuous sweep runs by itself unless stopped from outside
   assign cont_auto = ok & ~triggered_mode & ~stopped_q &
      (state_q == ssx_pkg::SSX_ST_START_VALUE);

   // ***********************************************
   // Step prescaler
   // ***********************************************
   // Step never finer than the minimum step time [R7]
   assign step_eff = (step_cycles < STEP_MIN) ? STEP_MIN : step_cycles;
   assign step_tick = running && (step_cnt_q >= step_eff - CNT_ONE);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         step_cnt_q <= '0;
      end else if (!running || step_tick || start_ev) begin
         step_cnt_q <= '0;
      end else begin
         step_cnt_q <= step_cnt_q + CNT_ONE;
      end
   end

   // ***********************************************
   // Sweep sequencer
   // ***********************************************
   // Priority: refusal, start, stop, hold, resume, auto run, stepping
   always_comb begin
      state_d = state_q;
      prog_d = prog_q;
      if (!ok) begin
         state_d = ssx_pkg::SSX_ST_START_VALUE;
         prog_d = ssx_pkg::PROG_FIRST;
      end else if (start_ev) begin
         // Also restarts from hold or after a stop in triggered modes [R16] [R18]
         state_d = ssx_pkg::SSX_ST_RUN_FWD;
         prog_d = ssx_pkg::PROG_FIRST;
      end else if (stop_ev) begin
         state_d = ssx_pkg::SSX_ST_START_VALUE; // [R15]
         prog_d = ssx_pkg::PROG_FIRST;
      end else if (hold_ev) begin
         state_d = ssx_pkg::SSX_ST_HOLD; // [R17]
      end else if (resume_ev) begin
         // Direction of the frozen leg is kept in ret_leg_q, or taken as return at the last shuttle position
         state_d = (shuttle && prog_q == ssx_pkg::PROG_LAST) || ret_leg_q ?
            ssx_pkg::SSX_ST_RUN_RETURN : ssx_pkg::SSX_ST_RUN_FWD;
      end else if (cont_auto) begin
         state_d = ssx_pkg::SSX_ST_RUN_FWD;
         prog_d = ssx_pkg::PROG_FIRST;
      end else if (step_tick) begin
         case (state_q)
            ssx_pkg::SSX_ST_RUN_FWD: begin
               if (prog_q != ssx_pkg::PROG_LAST) begin
                  prog_d = prog_q + PROG_ONE;
               end else if (shuttle) begin
                  state_d = ssx_pkg::SSX_ST_RUN_RETURN;
               end else if (triggered_mode) begin
                  state_d = ssx_pkg::SSX_ST_START_VALUE; // [R23]
                  prog_d = ssx_pkg::PROG_FIRST;
               end else begin
                  prog_d = ssx_pkg::PROG_FIRST;
               end
            end
            ssx_pkg::SSX_ST_RUN_RETURN: begin
               if (prog_q != ssx_pkg::PROG_FIRST) begin
                  prog_d = prog_q - PROG_ONE;
               end else if (triggered_mode) begin
                  state_d = ssx_pkg::SSX_ST_COMPLETE; // [R23]
               end else begin
                  state_d = ssx_pkg::SSX_ST_RUN_FWD;
               end
            end
            default: begin
               state_d = state_q;
            end
         endcase
      end
   end

   // State and progress registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= ssx_pkg::SSX_ST_START_VALUE;
         prog_q <= ssx_pkg::PROG_FIRST;
      end else begin
         state_q <= state_d;
         prog_q <= prog_d;
      end
   end

   // Leg held across a freeze so resume continues in the same direction
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ret_leg_q <= 1'b0;
      end else if (running) begin
         ret_leg_q <= (state_q == ssx_pkg::SSX_ST_RUN_RETURN);
      end
   end

   // Remembers an outside stop so continuous sweep does not restart itself
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stopped_q <= 1'b0;
      end else if (start_ev) begin
         stopped_q <= 1'b0;
      end else if (stop_ev) begin
         stopped_q <= 1'b1;
      end
   end

   // ***********************************************
   // Swept value and marker crossing
   // ***********************************************
   // Linear interpolation; log shaping happens downstream of this block
   assign diff_s = $signed({1'b0, stop_value}) - $signed({1'b0, start_value});
   assign prod_s = diff_s * $signed({1'b0, prog_q});
   assign val_s = $signed({2'b00, start_value}) +
      $signed(prod_s[VAL_W+ssx_pkg::PROG_W:ssx_pkg::PROG_W]);
   assign lin_value = val_s[VAL_W-1:0];
   assign reached = descend ? (lin_value <= marker_value) : (lin_value >= marker_value);

   // Low until the marker, clamped at both ends of the sweep [R4] [R6]
   assign marker_low = (prog_q < ssx_pkg::MK_MIN_IDX) ||
      (!reached && prog_q < ssx_pkg::MK_MAX_IDX);

   // ***********************************************
   // Sync output selection
   // ***********************************************
   always_comb begin
      sync_d = 1'b1;
      case (sync_output_select) // [R1]
         ssx_pkg::SSX_SYNC_REF_PHASE: begin
            // Phase MSB falls at wrap, so the output rises there [R2]
            sync_d = ~wave_phase_msb;
         end
         ssx_pkg::SSX_SYNC_SWEEP_LEVEL: begin
            sync_d = ~(running || state_q == ssx_pkg::SSX_ST_HOLD); // [R3]
         end
         ssx_pkg::SSX_SYNC_LEVEL_MARKER: begin
            if (state_q == ssx_pkg::SSX_ST_RUN_FWD) begin
               sync_d = ~marker_low; // [R4]
            end else if (state_q == ssx_pkg::SSX_ST_RUN_RETURN ||
                         state_q == ssx_pkg::SSX_ST_HOLD) begin
               sync_d = sync_out; // [R5]
            end else begin
               sync_d = 1'b1;
            end
         end
         ssx_pkg::SSX_SYNC_X_DRIVE: begin
            sync_d = 1'b0;
         end
         default: begin
            sync_d = 1'b1;
         end
      endcase
   end

   // Ramp follows elapsed time only, never the swept value [R8] [R9]
   always_comb begin
      if (!shuttle) begin
         xd_base = prog_q[ssx_pkg::PROG_W-1 -: XD_W];
      end else if (state_q == ssx_pkg::SSX_ST_RUN_RETURN || ret_leg_q &&
                   state_q == ssx_pkg::SSX_ST_HOLD || state_q == ssx_pkg::SSX_ST_COMPLETE) begin
         xd_base = {1'b1, ~prog_q[ssx_pkg::PROG_W-1 -: XD_W-1]};
      end else begin
         xd_base = {1'b0, prog_q[ssx_pkg::PROG_W-1 -: XD_W-1]};
      end
   end

   // Output registers for the sub-output pin
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync_out <= 1'b1;
         xdrive_code <= '0;
      end else begin
         sync_out <= sync_d;
         if (sync_output_select == ssx_pkg::SSX_SYNC_X_DRIVE) begin
            xdrive_code <= descend ? ~xd_base : xd_base; // [R10]
         end else begin
            xdrive_code <= '0;
         end
      end
   end

   // ***********************************************
   // Marker and center settings
   // ***********************************************
   // Copy commands win over a direct write in the same cycle [R11]
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         marker_value <= '0;
      end else if (copy_center_to_marker) begin
         marker_value <= center_value; // [R11]
      end else if (marker_wr) begin
         marker_value <= marker_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         center_value <= '0;
      end else if (copy_marker_to_center) begin
         center_value <= marker_value; // [R11]
      end else if (center_wr) begin
         center_value <= center_wdata;
      end
   end

   // ***********************************************
   // Status and parameter steering
   // ***********************************************
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         swept_value <= '0;
         sweep_state <= ssx_pkg::SSX_ST_START_VALUE;
         sweep_conflict <= 1'b0;
         param_override <= '0;
         halted_level_active <= 1'b0;
         halt_half_cycle <= 1'b0;
      end else begin
         swept_value <= lin_value;
         sweep_state <= state_d;
         sweep_conflict <= sweep_enable & conflict;
         // Static setting of the swept parameter is overridden [R21]
         param_override <= ok ? (ssx_pkg::TYPE_COUNT'(1) << sweep_type) : '0;
         halted_level_active <= ok & halted_output_level &
            (sweep_run_mode == ssx_pkg::SSX_RUN_GATED_SINGLE); // [R22]
         halt_half_cycle <= ok & halt_granularity &
            (sweep_run_mode == ssx_pkg::SSX_RUN_GATED_SINGLE); // [R22]
      end
   end

   // ***********************************************
   // Assertions
   // ***********************************************
   a_sweep_sync_fall: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
      sync_output_select == ssx_pkg::SSX_SYNC_SWEEP_LEVEL && start_ev ##1
      sync_output_select == ssx_pkg::SSX_SYNC_SWEEP_LEVEL |=> !sync_out)
      else $error("sweep level did not fall at sweep start");

   a_marker_return_hold: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
      sync_output_select == ssx_pkg::SSX_SYNC_LEVEL_MARKER &&
      state_q == ssx_pkg::SSX_ST_RUN_RETURN |=> sync_out == $past(sync_out))
      else $error("marker output changed on return leg");

   a_marker_min_low: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
      sync_output_select == ssx_pkg::SSX_SYNC_LEVEL_MARKER &&
      state_q == ssx_pkg::SSX_ST_RUN_FWD && prog_q < ssx_pkg::MK_MIN_IDX |=> !sync_out)
      else $error("marker output high inside minimum low time");

   a_edges_gated_off: assert property (@(posedge mclk) disable iff (!rst_n) // [R24]
      !external_control_enable |-> ext_fall == '0 && ext_rise == '0)
      else $error("external edge passed while control disabled");

   a_stop_to_start: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
      ok && stop_ev && !start_ev |=>
      state_q == ssx_pkg::SSX_ST_START_VALUE && prog_q == ssx_pkg::PROG_FIRST)
      else $error("external stop did not return to start value");

   a_hold_freezes: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
      ok && (hold_ev || state_q == ssx_pkg::SSX_ST_HOLD) && !start_ev && !stop_ev |=>
      prog_q == $past(prog_q) && (state_q == ssx_pkg::SSX_ST_HOLD || $past(resume_ev)))
      else $error("hold did not freeze progress");

   a_trig_in_hold: assert property (@(posedge mclk) disable iff (!rst_n) // [R18]
      ok && triggered_mode && trig_in && state_q == ssx_pkg::SSX_ST_HOLD |=>
      state_q == ssx_pkg::SSX_ST_RUN_FWD && prog_q == ssx_pkg::PROG_FIRST)
      else $error("trigger during hold did not restart");

   a_freq_refused: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
      sweep_type == ssx_pkg::SSX_TYPE_FREQ && waveform == ssx_pkg::SSX_WAVE_PULSE |=>
      state_q == ssx_pkg::SSX_ST_START_VALUE)
      else $error("frequency sweep ran on pulse waveform");

   a_copy_marker: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
      copy_center_to_marker |=> marker_value == $past(center_value))
      else $error("center to marker copy failed");

endmodule
`default_nettype wire

// ==== testbench/ssx_ext_ctl.sv ====
// External TTL control partner for start, stop and hold pins
`default_nettype none
module ssx_ext_ctl (
   input wire logic mclk,
   output var ssx_pkg::ssx_ext_s ext_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Pin driver
   // ****
   // Pins idle high, so only a deliberate drive makes an edge
   initial ext_pins = 3'h7;
   // Bit 2 start, 1 stop, 0 hold; changes only just after an edge
   task automatic drive(input int p, input logic l);
      @(posedge mclk);
      ext_pins[p] <= l;
   endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the sweep sync and external control block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // Stimulus and design
   // ****
   logic mclk = 0, rst_n = 0, trig = 0, ph = 0, en = 1, xen = 1, e;
   logic mwr = 0, cwr = 0, c2m = 0, m2c = 0, hlvl = 0, hgr = 0;
   logic [15:0] sv = 16'h0000, pv = 16'hFFFF, md = 16'h0000, cd = 16'h0000;
   logic [15:0] mv, cv, swv;
   logic [11:0] xd, xa;
   logic [4:0] ovr;
   logic sync, conf, hla, hhc;
   ssx_pkg::ssx_sync_sel_e sel = ssx_pkg::SSX_SYNC_SWEEP_LEVEL;
   ssx_pkg::ssx_run_mode_e mode = ssx_pkg::SSX_RUN_SINGLE;
   ssx_pkg::ssx_type_e typ = ssx_pkg::SSX_TYPE_FREQ;
   ssx_pkg::ssx_wave_e wav = ssx_pkg::SSX_WAVE_SINE;
   ssx_pkg::ssx_shape_e shp = ssx_pkg::SSX_SHAPE_LINEAR_SINGLE_DIRECTION;
   ssx_pkg::ssx_ext_s pins;
   ssx_pkg::ssx_state_e st;
   int n_fail = 0, n_tests = 0, m_st, seed = 32'hC263E274;
   // 50 MHz clock
   always #10 mclk = ~mclk;
   ssx_ext_ctl ext (.mclk(mclk), .ext_pins(pins));
   // Step length is fixed at the shortest sweep to keep runs short
   ssx_sweep_sync dut (.mclk(mclk), .rst_n(rst_n), .sync_output_select(sel),
      .sweep_run_mode(mode), .sweep_type(typ), .waveform(wav), .sweep_shape_function(shp),
      .sweep_enable(en), .external_control_enable(xen), .ext_pins(pins),
      .trig_in(trig), .wave_phase_msb(ph), .step_cycles(24'h000001),
      .start_value(sv), .stop_value(pv), .marker_wr(mwr), .marker_wdata(md),
      .center_wr(cwr), .center_wdata(cd), .copy_center_to_marker(c2m),
      .copy_marker_to_center(m2c), .halted_output_level(hlvl),
      .halt_granularity(hgr), .sync_out(sync), .xdrive_code(xd), .swept_value(swv),
      .marker_value(mv), .center_value(cv), .sweep_state(st),
      .sweep_conflict(conf), .param_override(ovr),
      .halted_level_active(hla), .halt_half_cycle(hhc));
   // ****
   // Tasks
   // ****
   // Four-state compare, so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Settle past the edge so its updates have landed
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Bench model of the sequencer state, compared with the design
   task automatic st_is(input int s);
      m_st = s;
      chk(st, m_st);
   endtask
   // Bounded wait for a sequencer state; running out counts as a mismatch
   task automatic wait_st(input int s);
      for (int i = 0; st !== s; i++) begin
         if (i > 33000) begin
            n_fail++;
            final_report();
         end
         step(1);
      end
   endtask
   // Pin edge, then one edge to act and two to show at the outputs
   task automatic pin(input int p, input logic l);
      ext.drive(p, l);
      step(3);
   endtask
   task automatic pulse;
      @(posedge mclk);
      trig <= 1;
      @(posedge mclk);
      trig <= 0;
      step(2);
   endtask
   // Write the source setting with random data, then copy it one way
   task automatic copy(input logic to_m);
      @(posedge mclk);
      cd <= 16'($random(seed));
      md <= 16'($random(seed));
      cwr <= to_m;
      mwr <= !to_m;
      @(posedge mclk);
      cwr <= 0;
      mwr <= 0;
      c2m <= to_m;
      m2c <= !to_m;
      @(posedge mclk);
      c2m <= 0;
      m2c <= 0;
      step(1);
   endtask
   task automatic final_report;
      if (n_fail == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      step(16);
      chk(sync, 1);
      chk(xd, 0);
      st_is(0);
      rst_n <= 1;
      pulse();
      st_is(1);
      chk(sync, 0);
      pin(1, 0);
      st_is(0);
      chk(sync, 1);
      pin(1, 1);
      pin(2, 0);
      st_is(1);
      pin(2, 1);
      step(40);
      pin(0, 0);
      st_is(3);
      sel <= ssx_pkg::SSX_SYNC_X_DRIVE;
      step(3);
      xa = xd;
      sv <= 16'hFFFF;
      pv <= 16'h0000;
      step(3);
      chk(xd, 12'(~xa));
      sv <= 16'h0000;
      pv <= 16'hFFFF;
      step(3);
      chk(xd, xa);
      pin(0, 1);
      st_is(1);
      step(40);
      pin(0, 0);
      pulse();
      st_is(1);
      chk(xd, 0);
      pin(0, 1);
      xen <= 0;
      pin(1, 0);
      st_is(1);
      pin(1, 1);
      xen <= 1;
      sel <= ssx_pkg::SSX_SYNC_SWEEP_LEVEL;
      // The whole one-way sweep, bounded in case it never ends
      wait_st(0);
      st_is(0);
      step(1);
      chk(sync, 1);
      // Marker at the start value: low time clamps to 16 steps
      sel <= ssx_pkg::SSX_SYNC_LEVEL_MARKER;
      pin(2, 0);
      step(6);
      chk(sync, 0);
      step(16);
      chk(sync, 1);
      pin(2, 1);
      copy(1);
      chk(mv, cd);
      copy(0);
      chk(cv, md);
      hlvl <= 1;
      hgr <= 1;
      for (int m = 0; m < 3; m++) begin
         mode <= ssx_pkg::ssx_run_mode_e'(m);
         step(3);
         chk(hla, m == 2);
         chk(hhc, m == 2);
      end
      for (int t = 0; t < 2; t++) begin
         for (int w = 0; w < 7; w++) begin
            typ <= ssx_pkg::ssx_type_e'(t);
            wav <= ssx_pkg::ssx_wave_e'(w);
            step(3);
            e = (w == 4 || w == 5 || (t == 0 && w == 2));
            chk(conf, e);
            chk(ovr, e ? 0 : 1 << t);
         end
      end
      // Shuttle with a marker never reached: sync must stay high on the way back
      md <= 16'hFFFF;
      mwr <= 1;
      shp <= ssx_pkg::SSX_SHAPE_LINEAR_SHUTTLE;
      sel <= ssx_pkg::SSX_SYNC_LEVEL_MARKER;
      pulse();
      mwr <= 0;
      wait_st(2);
      step(40);
      st_is(2);
      chk(sync, 1);
      pin(1, 0);
      st_is(0);
      chk(swv, sv);
      // Reference-phase form follows the inverted phase MSB
      sel <= ssx_pkg::SSX_SYNC_REF_PHASE;
      ph <= 1;
      step(3);
      chk(sync, 0);
      ph <= 0;
      step(3);
      chk(sync, 1);
      final_report();
   end
endmodule
`default_nettype wire
